// ==== rtl/ifeu_top.sv ====
// interrupt flag, enable and vectoring unit with AXI4-Lite registers
// assumes the core pushes/pops the stack on the pulses given here and
// that all inputs are synchronous to aclk
`timescale 1ns/1ps
module ifeu_top #(
  parameter int PCW   = 13,
  parameter bit LARGE = 1'b1
) (
  // clock and reset
  input  wire logic           aclk,
  input  wire logic           aresetn,
  // axi4-lite slave
  input  wire logic [7:0]     awaddr,
  input  wire logic           awvalid,
  output logic                awready,
  input  wire logic [31:0]    wdata,
  input  wire logic [3:0]     wstrb,
  input  wire logic           wvalid,
  output logic                wready,
  output logic [1:0]          bresp,
  output logic                bvalid,
  input  wire logic           bready,
  input  wire logic [7:0]     araddr,
  input  wire logic           arvalid,
  output logic                arready,
  output logic [31:0]         rdata,
  output logic [1:0]          rresp,
  output logic                rvalid,
  input  wire logic           rready,
  // peripheral events, one-cycle pulses
  input  wire logic           converter_done_evt,
  input  wire logic           serial_evt,
  input  wire logic           timebase_zero_evt,
  input  wire logic           timebase_one_evt,
  input  wire logic           std_timer_match_a_evt,
  input  wire logic           std_timer_match_p_evt,
  input  wire logic           periodic_timer0_match_a_evt,
  input  wire logic           periodic_timer0_match_p_evt,
  input  wire logic           periodic_timer1_match_a_evt,
  input  wire logic           periodic_timer1_match_p_evt,
  input  wire logic           eeprom_evt,
  input  wire logic           low_voltage_evt,
  // external pins
  input  wire logic           ext_pin_zero,
  input  wire logic           ext_pin_one,
  input  wire logic [1:0]     pull_select,
  output logic [1:0]          pull_enable,
  // core sequencer and stack
  input  wire logic           stack_full,
  input  wire logic           return_from_interrupt,
  output logic                stack_push,
  output logic [PCW-1:0]      vector_addr,
  output logic                stack_pop,
  output logic                wake
);
  typedef struct packed {
    logic                       gie;
    logic [ifeu_pkg::NUM_SRC-1:0] flag;
    logic [ifeu_pkg::NUM_SRC-1:0] en;
    logic [ifeu_pkg::NUM_MEM-1:0] mflag;
    logic [ifeu_pkg::NUM_MEM-1:0] men;
    logic [3:0]                 edge_sel;
    logic [1:0]                 pin_prev;
    logic                       awready;
    logic                       wready;
    logic                       aw_got;
    logic                       w_got;
    logic [7:0]                 waddr;
    logic [7:0]                 wbyte;
    logic                       wstb;
    logic                       bvalid;
    logic [1:0]                 bresp;
    logic                       arready;
    logic                       rvalid;
    logic [7:0]                 rbyte;
    logic [1:0]                 rresp;
    logic                       take;
    logic [3:0]                 src;
    logic [PCW-1:0]             vector;
    logic                       pop;
    logic                       wake;
    logic [1:0]                 pull;
  } ifeu_state_t;

  ifeu_state_t s_ff;
  ifeu_state_t nxt_s;
  logic [ifeu_pkg::NUM_MEM-1:0] mem_evt;
  logic [1:0]                   pins;
  logic [1:0]                   ext_evt;
  logic [7:0]                   g1_mask;

  // ----------------------------------------
  // register read view
  // ----------------------------------------
  function automatic logic is_mapped(input logic [7:0] a);
    return a <= ifeu_pkg::OFF_STATUS && a[1:0] == 2'h0;
  endfunction : is_mapped

  function automatic logic [7:0] rd_reg(input ifeu_state_t st,
                                        input logic [7:0]  a,
                                        input logic [7:0]  m);
    logic [7:0] v;
    v = ifeu_pkg::REG_RESET;
    case (a)
      ifeu_pkg::OFF_CTL0: v = {1'b0, st.flag[2:0], st.en[2:0], st.gie};
      ifeu_pkg::OFF_CTL1: v = {st.flag[3], st.flag[5], st.flag[4],
                               st.flag[6], st.en[3], st.en[5],
                               st.en[4], st.en[6]};
      ifeu_pkg::OFF_CTL2: v = {2'h0, st.flag[8:7], 2'h0, st.en[8:7]};
      ifeu_pkg::OFF_GRP0: v = {2'h0, st.mflag[1:0], 2'h0, st.men[1:0]};
      ifeu_pkg::OFF_GRP1: v = {st.mflag[5:2], st.men[5:2]} & m;
      ifeu_pkg::OFF_GRP2: v = {2'h0, st.mflag[7:6], 2'h0, st.men[7:6]};
      ifeu_pkg::OFF_EDGE: v = {4'h0, st.edge_sel};
      ifeu_pkg::OFF_STATUS: v = {3'h0, st.take, st.src};
      default: v = ifeu_pkg::REG_RESET;
    endcase
    return v;
  endfunction : rd_reg

  // ----------------------------------------
  // event collection and pin edges
  // ----------------------------------------
  // timer1 bits exist on the large part only
  assign g1_mask = LARGE ? 8'hFF : ifeu_pkg::GRP1_SMALL_MASK;
  assign mem_evt = {eeprom_evt, low_voltage_evt,
                    periodic_timer1_match_a_evt & LARGE,
                    periodic_timer1_match_p_evt & LARGE,
                    periodic_timer0_match_a_evt,
                    periodic_timer0_match_p_evt,
                    std_timer_match_a_evt, std_timer_match_p_evt};
  assign pins = {ext_pin_one, ext_pin_zero};

  generate
    for (genvar p = 0; p < 2; p++) begin : g_pin
      logic rise;
      logic fall;
      logic [1:0] sel;
      assign rise = pins[p] & ~s_ff.pin_prev[p];
      assign fall = ~pins[p] & s_ff.pin_prev[p];
      assign sel  = s_ff.edge_sel[2*p +: 2];
      assign ext_evt[p] = (sel == ifeu_pkg::EDGE_RISE && rise) ||
                          (sel == ifeu_pkg::EDGE_FALL && fall) ||
                          (sel == ifeu_pkg::EDGE_BOTH && (rise || fall));
    end
  endgenerate

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic [ifeu_pkg::NUM_SRC-1:0] pend;
    logic [ifeu_pkg::NUM_SRC-1:0] evt;
    logic [7:0]                   d;
    int                           pick;
    nxt_s = s_ff;
    pend = '0;
    evt = '0;
    d = '0;
    pick = 0;
    nxt_s.take = 1'b0;
    nxt_s.pop = 1'b0;
    // write channels, taken in either order
    if (awvalid && s_ff.awready) begin
      nxt_s.aw_got = 1'b1;
      nxt_s.waddr = awaddr;
    end
    if (wvalid && s_ff.wready) begin
      nxt_s.w_got = 1'b1;
      nxt_s.wbyte = wdata[7:0];
      nxt_s.wstb = wstrb[0];
    end
    if (bready && s_ff.bvalid) begin
      nxt_s.bvalid = 1'b0;
    end
    if (s_ff.aw_got && s_ff.w_got && !s_ff.bvalid) begin
      nxt_s.aw_got = 1'b0;
      nxt_s.w_got = 1'b0;
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp = is_mapped(s_ff.waddr) ? ifeu_pkg::RESP_OKAY
                                          : ifeu_pkg::RESP_SLVERR;
      d = s_ff.wbyte;
      if (s_ff.wstb) begin
        // only defined bits take the write
        case (s_ff.waddr)
          ifeu_pkg::OFF_CTL0: begin
            nxt_s.gie = d[0];
            nxt_s.en[2:0] = d[3:1];
            nxt_s.flag[2:0] = d[6:4];
          end
          ifeu_pkg::OFF_CTL1: begin
            {nxt_s.flag[3], nxt_s.flag[5], nxt_s.flag[4],
             nxt_s.flag[6]} = d[7:4];
            {nxt_s.en[3], nxt_s.en[5], nxt_s.en[4], nxt_s.en[6]} = d[3:0];
          end
          ifeu_pkg::OFF_CTL2: begin
            nxt_s.flag[8:7] = d[5:4];
            nxt_s.en[8:7] = d[1:0];
          end
          ifeu_pkg::OFF_GRP0: begin
            nxt_s.mflag[1:0] = d[5:4];
            nxt_s.men[1:0] = d[1:0];
          end
          ifeu_pkg::OFF_GRP1: begin
            nxt_s.mflag[5:2] = d[7:4] & g1_mask[7:4];
            nxt_s.men[5:2] = d[3:0] & g1_mask[3:0];
          end
          ifeu_pkg::OFF_GRP2: begin
            nxt_s.mflag[7:6] = d[5:4];
            nxt_s.men[7:6] = d[1:0];
          end
          ifeu_pkg::OFF_EDGE: nxt_s.edge_sel = d[3:0];
          default: nxt_s.gie = nxt_s.gie;
        endcase
      end
    end
    nxt_s.awready = !nxt_s.aw_got && !nxt_s.bvalid;
    nxt_s.wready = !nxt_s.w_got && !nxt_s.bvalid;
    // read channel, answer one edge after the address
    if (rready && s_ff.rvalid) begin
      nxt_s.rvalid = 1'b0;
    end
    if (arvalid && s_ff.arready) begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rbyte = rd_reg(s_ff, araddr, g1_mask);
      nxt_s.rresp = is_mapped(araddr) ? ifeu_pkg::RESP_OKAY
                                      : ifeu_pkg::RESP_SLVERR;
    end
    nxt_s.arready = !nxt_s.rvalid;
    // acceptance; low index wins
    pend = s_ff.flag & s_ff.en;
    for (int i = ifeu_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (pend[i]) begin
        pick = i;
      end
    end
    if (s_ff.gie && !stack_full && |pend) begin
      nxt_s.take = 1'b1;
      nxt_s.src = 4'(pick);
      nxt_s.vector = PCW'(ifeu_pkg::VEC_BASE + pick * ifeu_pkg::VEC_STEP);
      // serviced flag and global enable drop
      nxt_s.flag[pick] = 1'b0;
      nxt_s.gie = 1'b0;
    end
    // events set flags; set beats any clear
    nxt_s.mflag = nxt_s.mflag | mem_evt;
    evt[ifeu_pkg::SRC_EXT0] = ext_evt[0];
    evt[ifeu_pkg::SRC_EXT1] = ext_evt[1];
    evt[ifeu_pkg::SRC_SER] = serial_evt;
    evt[ifeu_pkg::SRC_ADC] = converter_done_evt;
    // any member sets its group flag
    evt[ifeu_pkg::SRC_MF0] = |mem_evt[1:0];
    evt[ifeu_pkg::SRC_MF1] = |mem_evt[5:2];
    evt[ifeu_pkg::SRC_MF2] = |mem_evt[7:6];
    evt[ifeu_pkg::SRC_TB0] = timebase_zero_evt;
    evt[ifeu_pkg::SRC_TB1] = timebase_one_evt;
    nxt_s.flag = nxt_s.flag | evt;
    nxt_s.pin_prev = pins;
    nxt_s.pop = return_from_interrupt;
    // any pending flag wakes the core
    nxt_s.wake = |nxt_s.flag || |nxt_s.mflag;
    // pull-high kept whatever the pin role
    nxt_s.pull = pull_select;
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign awready     = s_ff.awready;
  assign wready      = s_ff.wready;
  assign bvalid      = s_ff.bvalid;
  assign bresp       = s_ff.bresp;
  assign arready     = s_ff.arready;
  assign rvalid      = s_ff.rvalid;
  assign rdata       = {24'h000000, s_ff.rbyte};
  assign rresp       = s_ff.rresp;
  assign stack_push  = s_ff.take;
  assign vector_addr = s_ff.vector;
  assign stack_pop   = s_ff.pop;
  assign wake        = s_ff.wake;
  assign pull_enable = s_ff.pull;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [ifeu_pkg::NUM_SRC-1:0] pend_ff;
  always_ff @(posedge aclk) begin
    pend_ff <= s_ff.flag & s_ff.en;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence seq_accept;
    s_ff.take && !s_ff.gie;
  endsequence
  sequence seq_single;
    ##1 !s_ff.take;
  endsequence

  AST_GIE_BLOCKS: assert property (!s_ff.gie |=> !s_ff.take)
    else $error("accepted with global enable low");
  AST_STACK_HOLD: assert property (stack_full |=> !s_ff.take)
    else $error("accepted while stack full");
  AST_SERVICE_CLEARS: assert property (s_ff.take |->
      seq_accept ##0 seq_single)
    else $error("global enable not cleared on service");
  AST_ENABLED_ONLY: assert property (s_ff.take |-> pend_ff[s_ff.src])
    else $error("accepted source was not enabled and pending");
  AST_VECTOR: assert property (s_ff.take |-> s_ff.vector ==
      PCW'(ifeu_pkg::VEC_BASE + int'(s_ff.src) * ifeu_pkg::VEC_STEP))
    else $error("wrong vector address");
  AST_FLAG_SET: assert property (converter_done_evt |=> s_ff.flag[3])
    else $error("converter flag not set");
  AST_POP: assert property (return_from_interrupt |=> s_ff.pop)
    else $error("return did not pop");
  AST_WAKE: assert property ($rose(|s_ff.flag) |-> s_ff.wake)
    else $error("no wake on pending flag");
  AST_RSV_ZERO: assert property (s_ff.rvalid |-> rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  AST_GROUP: assert property (eeprom_evt |=>
      s_ff.flag[6] && s_ff.mflag[7])
    else $error("group flag not set by member");
  AST_EDGE: assert property (ext_evt[0] |=> s_ff.flag[0])
    else $error("pin edge did not set flag");
endmodule : ifeu_top

// ==== rtl/ifeu_pkg.sv ====
// constants for the interrupt flag and enable unit
// assumes a 32-bit AXI4-Lite register bus with byte addresses
package ifeu_pkg;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_CTL0   = 8'h00;
  localparam logic [7:0] OFF_CTL1   = 8'h04;
  localparam logic [7:0] OFF_CTL2   = 8'h08;
  localparam logic [7:0] OFF_GRP0   = 8'h0C;
  localparam logic [7:0] OFF_GRP1   = 8'h10;
  localparam logic [7:0] OFF_GRP2   = 8'h14;
  localparam logic [7:0] OFF_EDGE   = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1C;
  // ----------------------------------------
  // primary source index, low index wins
  // ----------------------------------------
  localparam int SRC_EXT0 = 0;
  localparam int SRC_EXT1 = 1;
  localparam int SRC_SER  = 2;
  localparam int SRC_ADC  = 3;
  localparam int SRC_MF0  = 4;
  localparam int SRC_MF1  = 5;
  localparam int SRC_MF2  = 6;
  localparam int SRC_TB0  = 7;
  localparam int SRC_TB1  = 8;
  localparam int NUM_SRC  = 9;
  // ----------------------------------------
  // group member index
  // ----------------------------------------
  localparam int MEM_STP  = 0;
  localparam int MEM_STA  = 1;
  localparam int MEM_P0P  = 2;
  localparam int MEM_P0A  = 3;
  localparam int MEM_P1P  = 4;
  localparam int MEM_P1A  = 5;
  localparam int MEM_LV   = 6;
  localparam int MEM_EE   = 7;
  localparam int NUM_MEM  = 8;
  // ----------------------------------------
  // encodings, masks, reset values
  // ----------------------------------------
  localparam logic [1:0] EDGE_OFF  = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] GRP1_SMALL_MASK = 8'h33;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int VEC_BASE = 4;
  localparam int VEC_STEP = 4;
endpackage : ifeu_pkg

// ==== dv/ifeu_core_model.sv ====
// core sequencer and stack model facing the interrupt unit
// assumes push and pop arrive as one-cycle pulses on aclk
`timescale 1ns/1ps
module ifeu_core_model #(
  parameter int PCW   = 13,
  parameter int DEPTH = 1
) (
  // clock and reset
  input  wire logic           aclk,
  input  wire logic           aresetn,
  // from the interrupt unit
  input  wire logic           stack_push,
  input  wire logic [PCW-1:0] vector_addr,
  input  wire logic           stack_pop,
  // bench command
  input  wire logic           ret_req,
  // to the interrupt unit
  output logic                stack_full,
  output logic                return_from_interrupt,
  // observation
  output int                  n_push,
  output logic [PCW-1:0]      last_vec
);
  // ----------------------------------------
  // stack depth
  // ----------------------------------------
  int depth;
  assign stack_full = (depth >= DEPTH);
  always @(posedge aclk) begin
    if (!aresetn) begin
      depth <= 0;
      n_push <= 0;
      last_vec <= '0;
      return_from_interrupt <= 1'b0;
    end else begin
      depth <= depth + int'(stack_push) - int'(stack_pop);
      if (stack_push) begin
        n_push <= n_push + 1;
        last_vec <= vector_addr;
      end
      return_from_interrupt <= ret_req && (depth > 0);
    end
  end
endmodule : ifeu_core_model

// ==== dv/interrupt_flag_enable_unit_bench.sv ====
// self-checking bench for the interrupt flag and enable unit
// assumes the core model holds one return address, so one accept fills it
`timescale 1ns/1ps
module interrupt_flag_enable_unit_bench;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
  logic        bready, arvalid, arready, rvalid, rready, ret_req;
  logic        stack_full, rfi, stack_push, stack_pop, wake;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd_val, rdata_small, rd_small;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp, pull_select, pull_enable, pins;
  logic [11:0] evts;
  logic [12:0] vector_addr, last_vec;
  logic [7:0]  ev_off [12];
  logic [7:0]  ev_bit [12];
  logic [7:0]  rg_off [7];
  logic [7:0]  rg_exp [7];
  int          n_push, mismatches, n_tests;
  // ----------------------------------------
  // design and core model
  // ----------------------------------------
  ifeu_top DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .converter_done_evt(evts[0]), .serial_evt(evts[1]),
    .timebase_zero_evt(evts[2]), .timebase_one_evt(evts[3]),
    .std_timer_match_a_evt(evts[4]), .std_timer_match_p_evt(evts[5]),
    .periodic_timer0_match_a_evt(evts[6]),
    .periodic_timer0_match_p_evt(evts[7]),
    .periodic_timer1_match_a_evt(evts[8]),
    .periodic_timer1_match_p_evt(evts[9]), .eeprom_evt(evts[10]),
    .low_voltage_evt(evts[11]), .ext_pin_zero(pins[0]),
    .ext_pin_one(pins[1]), .pull_select(pull_select),
    .pull_enable(pull_enable), .stack_full(stack_full),
    .return_from_interrupt(rfi), .stack_push(stack_push),
    .vector_addr(vector_addr), .stack_pop(stack_pop), .wake(wake));
  // small variant shares the bus; only its read data is watched
  ifeu_top #(.LARGE(1'b0)) DUT_small (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(), .bresp(), .bvalid(),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(),
    .rdata(rdata_small), .rresp(), .rvalid(), .rready(rready),
    .converter_done_evt(evts[0]), .serial_evt(evts[1]),
    .timebase_zero_evt(evts[2]), .timebase_one_evt(evts[3]),
    .std_timer_match_a_evt(evts[4]), .std_timer_match_p_evt(evts[5]),
    .periodic_timer0_match_a_evt(evts[6]),
    .periodic_timer0_match_p_evt(evts[7]),
    .periodic_timer1_match_a_evt(evts[8]),
    .periodic_timer1_match_p_evt(evts[9]), .eeprom_evt(evts[10]),
    .low_voltage_evt(evts[11]), .ext_pin_zero(pins[0]),
    .ext_pin_one(pins[1]), .pull_select(pull_select), .pull_enable(),
    .stack_full(stack_full), .return_from_interrupt(rfi),
    .stack_push(), .vector_addr(), .stack_pop(), .wake());
  ifeu_core_model core (.aclk(aclk), .aresetn(aresetn),
    .stack_push(stack_push), .vector_addr(vector_addr),
    .stack_pop(stack_pop), .ret_req(ret_req), .stack_full(stack_full),
    .return_from_interrupt(rfi), .n_push(n_push), .last_vec(last_vec));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string msg);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bit aw_ok = 1'b0;
    bit w_ok  = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h000000, d};
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1 && !aw_ok) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1 && !w_ok) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!(aw_ok && w_ok));
    do begin
      @(posedge aclk);
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
    end while (arready !== 1'b1);
    arvalid <= 1'b0;
    do begin
      @(posedge aclk);
    end while (rvalid !== 1'b1);
    rd_val = rdata;
    rd_small = rdata_small;
    resp = rresp;
    rready <= 1'b0;
    chk(rd_val, {24'h000000, exp}, $sformatf("read %h", a));
  endtask : rc
  task automatic pulse(input int i);
    @(posedge aclk);
    evts[i] <= 1'b1;
    @(posedge aclk);
    evts[i] <= 1'b0;
  endtask : pulse
  task automatic ret();
    @(posedge aclk);
    ret_req <= 1'b1;
    @(posedge aclk);
    ret_req <= 1'b0;
  endtask : ret
  // fixed wait: an absent accept can only be seen by waiting
  task automatic want_push(input int cnt, input int src);
    int n0 = n_push;
    repeat (12) @(posedge aclk);
    chk(n_push - n0, cnt, "accept count");
    if (cnt > 0) begin
      chk(last_vec, 13'(ifeu_pkg::VEC_BASE + ifeu_pkg::VEC_STEP * src),
          "vector");
    end
  endtask : want_push
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run
  // ----------------------------------------
  // clock and watchdog
  // ----------------------------------------
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  initial begin
    repeat (40000) @(posedge aclk);
    mismatches++;
    complete_run();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, ret_req} = '0;
    {awaddr, araddr, wdata, wstrb, pull_select, pins, evts} = '0;
    mismatches = 0;
    n_tests = 0;
    ev_off = '{ifeu_pkg::OFF_CTL1, ifeu_pkg::OFF_CTL0, ifeu_pkg::OFF_CTL2,
      ifeu_pkg::OFF_CTL2, ifeu_pkg::OFF_GRP0, ifeu_pkg::OFF_GRP0,
      ifeu_pkg::OFF_GRP1, ifeu_pkg::OFF_GRP1, ifeu_pkg::OFF_GRP1,
      ifeu_pkg::OFF_GRP1, ifeu_pkg::OFF_GRP2, ifeu_pkg::OFF_GRP2};
    ev_bit = '{8'h80, 8'h40, 8'h10, 8'h20, 8'h20, 8'h10, 8'h20, 8'h10,
      8'h80, 8'h40, 8'h20, 8'h10};
    rg_off = '{ifeu_pkg::OFF_CTL0, ifeu_pkg::OFF_CTL1, ifeu_pkg::OFF_CTL2,
      ifeu_pkg::OFF_GRP0, ifeu_pkg::OFF_GRP1, ifeu_pkg::OFF_GRP2,
      ifeu_pkg::OFF_EDGE};
    rg_exp = '{8'h7E, 8'hFE, 8'h32, 8'h32, 8'hFE, 8'h32, 8'h0E};
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    pull_select <= 2'h2;
    for (int i = 0; i < 7; i++) begin
      rc(rg_off[i], 8'h00);
      wr(rg_off[i], 8'hFE);
      rc(rg_off[i], rg_exp[i]);
      if (rg_off[i] == ifeu_pkg::OFF_GRP1) begin
        chk(rd_small, 32'h00000032, "small group 1");
      end
      wr(rg_off[i], 8'h00);
    end
    rc(8'h20, 8'h00);
    chk(resp, ifeu_pkg::RESP_SLVERR, "unmapped read");
    wr(8'h20, 8'hFF);
    chk(resp, ifeu_pkg::RESP_SLVERR, "unmapped write");
    chk(pull_enable, 2'h2, "pull");
    $display("test registers done");
    for (int i = 0; i < 12; i++) begin
      repeat (2) @(posedge aclk);
      chk(wake, 1'b0, "wake idle");
      pulse(i);
      rc(ev_off[i], ev_bit[i]);
      chk(wake, 1'b1, "wake");
      wr(ev_off[i], 8'h00);
      wr(ifeu_pkg::OFF_CTL1, 8'h00);
    end
    $display("test event flags done");
    for (int m = 0; m < 4; m++) begin
      wr(ifeu_pkg::OFF_EDGE, 8'(m * 5));
      wr(ifeu_pkg::OFF_CTL0, 8'h00);
      pins <= 2'h3;
      repeat (4) @(posedge aclk);
      rc(ifeu_pkg::OFF_CTL0, m[0] ? 8'h30 : 8'h00);
      wr(ifeu_pkg::OFF_CTL0, 8'h00);
      pins <= 2'h0;
      repeat (4) @(posedge aclk);
      rc(ifeu_pkg::OFF_CTL0, m[1] ? 8'h30 : 8'h00);
    end
    $display("test pin edges done");
    wr(ifeu_pkg::OFF_CTL1, 8'h08);
    pulse(0);
    want_push(0, 0);
    rc(ifeu_pkg::OFF_CTL1, 8'h88);
    wr(ifeu_pkg::OFF_CTL0, 8'h01);
    want_push(1, ifeu_pkg::SRC_ADC);
    rc(ifeu_pkg::OFF_CTL1, 8'h08);
    rc(ifeu_pkg::OFF_CTL0, 8'h00);
    wr(ifeu_pkg::OFF_CTL2, 8'h01);
    pulse(2);
    wr(ifeu_pkg::OFF_CTL0, 8'h01);
    want_push(0, 0);
    ret();
    want_push(1, ifeu_pkg::SRC_TB0);
    ret();
    wr(ifeu_pkg::OFF_CTL2, 8'h00);
    pulse(3);
    wr(ifeu_pkg::OFF_CTL0, 8'h01);
    want_push(0, 0);
    rc(ifeu_pkg::OFF_CTL2, 8'h20);
    $display("test accept done");
    wr(ifeu_pkg::OFF_CTL0, 8'h00);
    wr(ifeu_pkg::OFF_CTL1, 8'h01);
    wr(ifeu_pkg::OFF_CTL2, 8'h22);
    pulse(10);
    wr(ifeu_pkg::OFF_CTL0, 8'h01);
    want_push(1, ifeu_pkg::SRC_MF2);
    rc(ifeu_pkg::OFF_CTL1, 8'h01);
    rc(ifeu_pkg::OFF_GRP2, 8'h20);
    ret();
    wr(ifeu_pkg::OFF_CTL0, 8'h01);
    want_push(1, ifeu_pkg::SRC_TB1);
    ret();
    wr(ifeu_pkg::OFF_CTL0, 8'h03);
    pins <= 2'h3;
    want_push(1, ifeu_pkg::SRC_EXT0);
    rc(ifeu_pkg::OFF_CTL0, 8'h22);
    ret();
    $display("test priority and pins done");
    complete_run();
  end
endmodule : interrupt_flag_enable_unit_bench
